// ===== core/bgp_evt.v
// sticky event flags, cleared by a read, a new event wins over the clear
`timescale 1ns/10ps
module bgp_evt #(
	parameter WIDTH = 11
) (
	input wire hclk,
	input wire hresetn,
	input wire [WIDTH-1:0] event_set,
	input wire clear,
	output reg [WIDTH-1:0] status
);

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status <= {WIDTH{1'b0}};
		end else if (clear) begin
			status <= event_set;
		end else begin
			status <= status | event_set;
		end
	end

endmodule

// ===== core/bgp_gpio.v
// three eight-line board ports behind an AHB-Lite register slave
//
// Summary of operation
// - three ports, eight lines each, per-line direction
// - each port has values and directions registers
// - register bit n maps to line n
// - value registers at three consecutive indices
// - direction registers consecutive; set bit means output
// - user port lines all freely configurable
// - control line 0 input, low means active
// - any kick line change restarts external watchdog
// - control line 2 high enables watchdog
// - control line 4 input, high means fired
// - control line 5 low unlocks boot memory
// - control line 7 low enables flash disk
// - peripheral lines 0,1 select first serial mode
// - peripheral lines 2,3 select second serial mode
// - peripheral lines 6,7 read switches, low on
`timescale 1ns/10ps
module bgp_gpio (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg hreadyout,
	output reg hresp,
	output reg [31:0] hrdata,
	input wire firmware_access,
	input wire [7:0] user_port_in,
	output wire [7:0] user_port_out,
	output wire [7:0] user_port_oe,
	input wire [7:0] system_control_port_in,
	output wire [7:0] system_control_port_out,
	output wire [7:0] system_control_port_oe,
	input wire [7:0] peripheral_control_port_in,
	output wire [7:0] peripheral_control_port_out,
	output wire [7:0] peripheral_control_port_oe,
	output reg irq,
	output reg external_watchdog_enable,
	output reg external_watchdog_kick,
	output reg external_watchdog_fired,
	output reg undervoltage_indication,
	output reg [1:0] first_serial_port_mode,
	output reg [1:0] second_serial_port_mode,
	output reg user_lamp_one,
	output reg user_lamp_two,
	output reg [1:0] dip_switch_unit
);
`include "bgp_map.vh"

	// bus transfer states
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_WAIT = 3'b010;
	localparam [2:0] ST_DONE = 3'b100;

	reg [2:0] state;
	reg [2:0] next_state;
	reg [9:0] addr_idx;
	reg addr_write;
	reg addr_word;

	wire take;
	wire do_write;
	wire do_read;
	wire wr_p0_values;
	wire wr_p1_values;
	wire wr_p2_values;
	wire wr_p0_dirs;
	wire wr_p1_dirs;
	wire wr_p2_dirs;
	wire wr_mask;
	wire rd_status;

	wire [7:0] p0_dirs;
	wire [7:0] p1_dirs;
	wire [7:0] p2_dirs;
	wire [7:0] p0_sample;
	wire [7:0] p1_sample;
	wire [7:0] p2_sample;
	wire [7:0] p0_values;
	wire [7:0] p1_values;
	wire [7:0] p2_values;

	reg [7:0] p0_prev;
	reg [7:0] p1_prev;
	reg [7:0] p2_prev;
	reg sample_valid;
	reg sample_seen;
	reg kick_prev;

	reg [`BGP_EVT_WIDTH-1:0] evt_mask;
	wire [`BGP_EVT_WIDTH-1:0] evt_status;
	reg [`BGP_EVT_WIDTH-1:0] evt_set;
	reg [31:0] rd_value;

	// address phase accepted
	assign take = hsel & hready & htrans[`BGP_HTRANS_NONSEQ];

	// register side effects happen in the data phase, one wait state in
	assign do_write = (state == ST_WAIT) & addr_write & addr_word;
	assign do_read = (state == ST_WAIT) & ~addr_write;

	assign wr_p0_values = do_write & (addr_idx == `BGP_IDX_P0_VALUES);
	assign wr_p1_values = do_write & (addr_idx == `BGP_IDX_P1_VALUES);
	assign wr_p2_values = do_write & (addr_idx == `BGP_IDX_P2_VALUES);
	assign wr_p0_dirs = do_write & (addr_idx == `BGP_IDX_P0_DIRS);
	assign wr_p1_dirs = do_write & (addr_idx == `BGP_IDX_P1_DIRS);
	assign wr_p2_dirs = do_write & (addr_idx == `BGP_IDX_P2_DIRS);
	assign wr_mask = do_write & (addr_idx == `BGP_IDX_EVT_MASK);
	assign rd_status = do_read & (addr_idx == `BGP_IDX_EVT_STATUS);

	// user port: no fixed board function on any line
	bgp_port #(
		.IN_ONLY(`BGP_P0_IN_ONLY),
		.PROTECT(`BGP_P0_PROTECT)
	) u_user_port (
		.hclk(hclk),
		.hresetn(hresetn),
		.wr_values(wr_p0_values),
		.wr_dirs(wr_p0_dirs),
		.wdata(hwdata[7:0]),
		.fw_access(firmware_access),
		.line_in(user_port_in),
		.line_out(user_port_out),
		.line_oe(user_port_oe),
		.dirs(p0_dirs),
		.line_sample(p0_sample)
	);

	// system control port: watchdog, boot memory and flash disk lines
	bgp_port #(
		.IN_ONLY(`BGP_P1_IN_ONLY),
		.PROTECT(`BGP_P1_PROTECT)
	) u_system_control_port (
		.hclk(hclk),
		.hresetn(hresetn),
		.wr_values(wr_p1_values),
		.wr_dirs(wr_p1_dirs),
		.wdata(hwdata[7:0]),
		.fw_access(firmware_access),
		.line_in(system_control_port_in),
		.line_out(system_control_port_out),
		.line_oe(system_control_port_oe),
		.dirs(p1_dirs),
		.line_sample(p1_sample)
	);

	// peripheral control port: serial modes, lamps and switches
	bgp_port #(
		.IN_ONLY(`BGP_P2_IN_ONLY),
		.PROTECT(`BGP_P2_PROTECT)
	) u_peripheral_control_port (
		.hclk(hclk),
		.hresetn(hresetn),
		.wr_values(wr_p2_values),
		.wr_dirs(wr_p2_dirs),
		.wdata(hwdata[7:0]),
		.fw_access(firmware_access),
		.line_in(peripheral_control_port_in),
		.line_out(peripheral_control_port_out),
		.line_oe(peripheral_control_port_oe),
		.dirs(p2_dirs),
		.line_sample(p2_sample)
	);

	// value readback: outputs show the driven value, inputs the pin
	assign p0_values = (user_port_out & p0_dirs) | (p0_sample & ~p0_dirs);
	assign p1_values = (system_control_port_out & p1_dirs) | (p1_sample & ~p1_dirs);
	assign p2_values = (peripheral_control_port_out & p2_dirs) | (p2_sample & ~p2_dirs);

	// bus transfer sequencing
	always @* begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (take) begin
					next_state = ST_WAIT;
				end
			end
			ST_WAIT: begin
				next_state = ST_DONE;
			end
			ST_DONE: begin
				if (take) begin
					next_state = ST_WAIT;
				end else begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= ST_IDLE;
			addr_idx <= 10'h000;
			addr_write <= 1'b0;
			addr_word <= 1'b0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			state <= next_state;
			if (take) begin
				addr_idx <= haddr[11:2];
				addr_write <= hwrite;
				addr_word <= (hsize == `BGP_HSIZE_WORD);
			end
			hreadyout <= (next_state != ST_WAIT);
			hresp <= 1'b0;
		end
	end

	// read multiplexer; unmapped indices read zero
	always @* begin
		rd_value = 32'h0000_0000;
		case (addr_idx)
			`BGP_IDX_P0_VALUES: rd_value = {24'h000000, p0_values};
			`BGP_IDX_P1_VALUES: rd_value = {24'h000000, p1_values};
			`BGP_IDX_P2_VALUES: rd_value = {24'h000000, p2_values};
			`BGP_IDX_P0_DIRS: rd_value = {24'h000000, p0_dirs};
			`BGP_IDX_P1_DIRS: rd_value = {24'h000000, p1_dirs};
			`BGP_IDX_P2_DIRS: rd_value = {24'h000000, p2_dirs};
			`BGP_IDX_EVT_STATUS: rd_value = {21'h00000, evt_status};
			`BGP_IDX_EVT_MASK: rd_value = {21'h00000, evt_mask};
			default: rd_value = 32'h0000_0000;
		endcase
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (do_read) begin
			hrdata <= rd_value;
		end
	end

	// event detection on sampled input lines
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			p0_prev <= 8'h00;
			p1_prev <= 8'h00;
			p2_prev <= 8'h00;
			sample_seen <= 1'b0;
			sample_valid <= 1'b0;
		end else begin
			p0_prev <= p0_sample;
			p1_prev <= p1_sample;
			p2_prev <= p2_sample;
			// history holds a real sample only from the second edge on
			sample_seen <= 1'b1;
			sample_valid <= sample_seen;
		end
	end

	always @* begin
		evt_set = {`BGP_EVT_WIDTH{1'b0}};
		if (sample_valid) begin
			// any change on a user line configured as input
			evt_set[`BGP_EVT_P0_LO+7:`BGP_EVT_P0_LO] = (p0_sample ^ p0_prev) & ~p0_dirs;
			// undervoltage or isolated interrupt going active (low)
			evt_set[`BGP_EVT_UNDERVOLT] = p1_prev[`BGP_P1_UNDERVOLT] &
				~p1_sample[`BGP_P1_UNDERVOLT];
			// watchdog history going to fired (high)
			evt_set[`BGP_EVT_WD_FIRED] = ~p1_prev[`BGP_P1_WD_FIRED] &
				p1_sample[`BGP_P1_WD_FIRED];
			evt_set[`BGP_EVT_DIP] = (p2_sample[`BGP_P2_DIP_ONE] ^ p2_prev[`BGP_P2_DIP_ONE]) |
				(p2_sample[`BGP_P2_DIP_TWO] ^ p2_prev[`BGP_P2_DIP_TWO]);
		end
	end

	bgp_evt #(
		.WIDTH(`BGP_EVT_WIDTH)
	) u_evt (
		.hclk(hclk),
		.hresetn(hresetn),
		.event_set(evt_set),
		.clear(rd_status),
		.status(evt_status)
	);

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			evt_mask <= `BGP_RST_MASK;
			irq <= 1'b0;
		end else begin
			if (wr_mask) begin
				evt_mask <= hwdata[`BGP_EVT_WIDTH-1:0];
			end
			irq <= |(evt_status & evt_mask);
		end
	end

	// board function outputs, decoded from the driven lines and the sampled input lines
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			kick_prev <= 1'b0;
			external_watchdog_kick <= 1'b0;
			external_watchdog_enable <= 1'b0;
			external_watchdog_fired <= 1'b0;
			undervoltage_indication <= 1'b0;
			first_serial_port_mode <= `BGP_MODE_RS232;
			second_serial_port_mode <= `BGP_MODE_RS232;
			user_lamp_one <= 1'b0;
			user_lamp_two <= 1'b0;
			dip_switch_unit <= 2'h0;
		end else begin
			kick_prev <= system_control_port_out[`BGP_P1_WD_KICK] &
				system_control_port_oe[`BGP_P1_WD_KICK];
			// either edge of the kick line restarts the watchdog
			external_watchdog_kick <= kick_prev ^ (system_control_port_out[`BGP_P1_WD_KICK] &
				system_control_port_oe[`BGP_P1_WD_KICK]);
			external_watchdog_enable <= system_control_port_out[`BGP_P1_WD_ENABLE] &
				system_control_port_oe[`BGP_P1_WD_ENABLE];
			external_watchdog_fired <= p1_sample[`BGP_P1_WD_FIRED];
			undervoltage_indication <= ~p1_sample[`BGP_P1_UNDERVOLT];
			first_serial_port_mode <= serial_mode(peripheral_control_port_out[1:0] &
				peripheral_control_port_oe[1:0]);
			second_serial_port_mode <= serial_mode(peripheral_control_port_out[3:2] &
				peripheral_control_port_oe[3:2]);
			user_lamp_one <= peripheral_control_port_out[`BGP_P2_LAMP_ONE] &
				peripheral_control_port_oe[`BGP_P2_LAMP_ONE];
			user_lamp_two <= peripheral_control_port_out[`BGP_P2_LAMP_TWO] &
				peripheral_control_port_oe[`BGP_P2_LAMP_TWO];
			dip_switch_unit <= ~{p2_sample[`BGP_P2_DIP_TWO], p2_sample[`BGP_P2_DIP_ONE]};
		end
	end

	// line pair to mode: low line clear is rs232, else high line picks
	function [1:0] serial_mode;
		input [1:0] lines;
		begin
			if (!lines[0]) begin
				serial_mode = `BGP_MODE_RS232;
			end else if (!lines[1]) begin
				serial_mode = `BGP_MODE_RS422;
			end else begin
				serial_mode = `BGP_MODE_RS485;
			end
		end
	endfunction

endmodule

// ===== core/bgp_map.vh
// register map, field positions, reset values and codes of the board port block
`ifndef BGP_MAP_VH
`define BGP_MAP_VH

// register indices; byte address is four times the index
`define BGP_IDX_P0_VALUES 10'h078
`define BGP_IDX_P1_VALUES 10'h079
`define BGP_IDX_P2_VALUES 10'h07a
`define BGP_IDX_P0_DIRS 10'h098
`define BGP_IDX_P1_DIRS 10'h099
`define BGP_IDX_P2_DIRS 10'h09a
`define BGP_IDX_EVT_STATUS 10'h0a0
`define BGP_IDX_EVT_MASK 10'h0a1

// reset values
`define BGP_RST_VALUES 8'h00
`define BGP_RST_DIRS 8'h00
`define BGP_RST_MASK 11'h000

// lines that stay inputs whatever the direction bit says
`define BGP_P0_IN_ONLY 8'h00
`define BGP_P1_IN_ONLY 8'h59
`define BGP_P2_IN_ONLY 8'hc0

// lines whose value only firmware may change
`define BGP_P0_PROTECT 8'h00
`define BGP_P1_PROTECT 8'ha0
`define BGP_P2_PROTECT 8'h00

// system control port lines
`define BGP_P1_UNDERVOLT 0
`define BGP_P1_WD_KICK 1
`define BGP_P1_WD_ENABLE 2
`define BGP_P1_WD_FIRED 4
`define BGP_P1_BOOT_BLOCK 5
`define BGP_P1_FLASH_DIS 7

// peripheral control port lines
`define BGP_P2_SER1_LO 0
`define BGP_P2_SER1_HI 1
`define BGP_P2_SER2_LO 2
`define BGP_P2_SER2_HI 3
`define BGP_P2_LAMP_ONE 4
`define BGP_P2_LAMP_TWO 5
`define BGP_P2_DIP_ONE 6
`define BGP_P2_DIP_TWO 7

// event status bits
`define BGP_EVT_WIDTH 11
`define BGP_EVT_P0_LO 0
`define BGP_EVT_UNDERVOLT 8
`define BGP_EVT_WD_FIRED 9
`define BGP_EVT_DIP 10

// serial line mode codes
`define BGP_MODE_RS232 2'h0
`define BGP_MODE_RS422 2'h1
`define BGP_MODE_RS485 2'h2

// bus codes
`define BGP_HTRANS_NONSEQ 1
`define BGP_HSIZE_WORD 3'h2

`endif

// ===== core/bgp_port.v
// one eight-line port: value and direction registers and pin drive
`timescale 1ns/10ps
module bgp_port #(
	parameter [7:0] IN_ONLY = 8'h00,
	parameter [7:0] PROTECT = 8'h00
) (
	input wire hclk,
	input wire hresetn,
	input wire wr_values,
	input wire wr_dirs,
	input wire [7:0] wdata,
	input wire fw_access,
	input wire [7:0] line_in,
	output reg [7:0] line_out,
	output reg [7:0] line_oe,
	output reg [7:0] dirs,
	output reg [7:0] line_sample
);
`include "bgp_map.vh"

	wire [7:0] wmask;
	wire [7:0] next_dirs;

	// protected bits follow a write only while firmware has access
	assign wmask = fw_access ? 8'hff : ~PROTECT;
	assign next_dirs = wdata & ~IN_ONLY;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			line_out <= `BGP_RST_VALUES;
			dirs <= `BGP_RST_DIRS;
			line_oe <= `BGP_RST_DIRS;
			line_sample <= 8'h00;
		end else begin
			line_sample <= line_in;
			if (wr_values) begin
				line_out <= (wdata & wmask) | (line_out & ~wmask);
			end
			if (wr_dirs) begin
				dirs <= next_dirs;
				line_oe <= next_dirs;
			end
		end
	end

endmodule

// ===== sim/bgp_board.sv
// board circuits on the far side of the three ports
`timescale 1ns/10ps
module bgp_board (
	input wire [7:0] user_port_out,
	input wire [7:0] user_port_oe,
	input wire [7:0] system_control_port_out,
	input wire [7:0] system_control_port_oe,
	input wire [7:0] peripheral_control_port_out,
	input wire [7:0] peripheral_control_port_oe,
	input wire [7:0] ext_user,
	input wire [7:0] ext_sys,
	input wire [7:0] ext_per,
	output wire [7:0] user_port_in,
	output wire [7:0] system_control_port_in,
	output wire [7:0] peripheral_control_port_in,
	output integer kicks
);
	// a driven line shows the driver, a free line the outside level
	assign user_port_in = (user_port_oe & user_port_out) | (~user_port_oe & ext_user);
	assign system_control_port_in = (system_control_port_oe & system_control_port_out)
		| (~system_control_port_oe & ext_sys);
	assign peripheral_control_port_in = (peripheral_control_port_oe & peripheral_control_port_out)
		| (~peripheral_control_port_oe & ext_per);
	initial kicks = 0;
	// watchdog restarts on every level change of the kick line
	always @(system_control_port_in[1]) if ($time > 0) kicks = kicks + 1;
endmodule

// ===== sim/bgp_gpio_props.sv
// assertions on the board port block pins and bus
`timescale 1ns/10ps
`include "bgp_map.vh"
module bgp_gpio_props (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [1:0] htrans,
	input wire hready,
	input wire hreadyout,
	input wire hresp,
	input wire [7:0] system_control_port_out,
	input wire [7:0] system_control_port_oe,
	input wire [7:0] system_control_port_in,
	input wire [7:0] peripheral_control_port_out,
	input wire [7:0] peripheral_control_port_oe,
	input wire [7:0] peripheral_control_port_in,
	input wire irq,
	input wire external_watchdog_enable,
	input wire external_watchdog_kick,
	input wire external_watchdog_fired,
	input wire undervoltage_indication,
	input wire [1:0] first_serial_port_mode,
	input wire [1:0] second_serial_port_mode,
	input wire user_lamp_one,
	input wire user_lamp_two,
	input wire [1:0] dip_switch_unit
);
	wire [7:0] s_drv = system_control_port_out & system_control_port_oe;
	wire [7:0] p_drv = peripheral_control_port_out & peripheral_control_port_oe;
	function [1:0] mode_of(input [1:0] l);
		mode_of = !l[0] ? `BGP_MODE_RS232 : (l[1] ? `BGP_MODE_RS485 : `BGP_MODE_RS422);
	endfunction
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	bus_wait_a: assert property (hsel && hready && htrans[1] |=> !hreadyout ##1 hreadyout)
		else $error("bus wait state wrong");
	bus_okay_a: assert property (!hresp)
		else $error("bus response not okay");
	kick_pulse_a: assert property ($changed(s_drv[1]) |=> external_watchdog_kick)
		else $error("kick line change gave no pulse");
	wd_enable_a: assert property (external_watchdog_enable == $past(s_drv[2]))
		else $error("watchdog enable wrong");
	lamp_drive_a: assert property ({user_lamp_two, user_lamp_one} == $past(p_drv[5:4]))
		else $error("lamp drive wrong");
	fixed_input_a: assert property ((system_control_port_oe & `BGP_P1_IN_ONLY) == 8'h00
		&& (peripheral_control_port_oe & `BGP_P2_IN_ONLY) == 8'h00)
		else $error("input line driven");
	dip_read_a: assert property ($past(hresetn, 2) |->
		dip_switch_unit == ~$past(peripheral_control_port_in[7:6], 2))
		else $error("switch state wrong");
	uv_fired_a: assert property ($past(hresetn, 2) |->
		undervoltage_indication == !$past(system_control_port_in[0], 2)
		&& external_watchdog_fired == $past(system_control_port_in[4], 2))
		else $error("undervoltage or fired state wrong");
	serial_one_a: assert property (first_serial_port_mode == mode_of($past(p_drv[1:0])))
		else $error("first serial mode wrong");
	serial_two_a: assert property (second_serial_port_mode == mode_of($past(p_drv[3:2])))
		else $error("second serial mode wrong");
	kick_seen_c: cover property (external_watchdog_kick);
	irq_rise_c: cover property ($rose(irq));
	wait_state_c: cover property (!hreadyout);
endmodule
bind bgp_gpio bgp_gpio_props bgp_gpio_props_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.htrans(htrans), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.system_control_port_out(system_control_port_out), .system_control_port_in(system_control_port_in),
	.system_control_port_oe(system_control_port_oe), .irq(irq),
	.peripheral_control_port_out(peripheral_control_port_out),
	.peripheral_control_port_oe(peripheral_control_port_oe),
	.peripheral_control_port_in(peripheral_control_port_in),
	.external_watchdog_enable(external_watchdog_enable),
	.external_watchdog_kick(external_watchdog_kick),
	.external_watchdog_fired(external_watchdog_fired),
	.undervoltage_indication(undervoltage_indication),
	.first_serial_port_mode(first_serial_port_mode),
	.second_serial_port_mode(second_serial_port_mode), .user_lamp_one(user_lamp_one),
	.user_lamp_two(user_lamp_two), .dip_switch_unit(dip_switch_unit));

// ===== sim/board_gpio_ports_tb.sv
// self-checking bench for the board port block
`timescale 1ns/10ps
`include "bgp_map.vh"
module board_gpio_ports_tb;
	reg hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, fw = 0;
	reg [1:0] htrans = 0;
	reg [2:0] hsize = 0;
	reg [31:0] haddr = 0, hwdata = 0, rd;
	// released kick line idles low, so only driven level changes kick
	reg [7:0] ext [0:2] = '{8'h3c, 8'hed, 8'hff};
	wire hreadyout, hresp, irq, wde, wdk, wdf, uv, l1, l2;
	wire [31:0] hrdata;
	wire [1:0] m1, m2, dip;
	wire [7:0] uo, ue, ui, so, se, si, po, pe, pi;
	integer fails = 0, samples_checked = 0, kicks, pulses = 0;
	always #4 hclk = ~hclk;
	always @(posedge hclk) if (wdk === 1'b1) pulses <= pulses + 1;
	bgp_gpio bgp_gpio_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .firmware_access(fw),
		.user_port_in(ui), .user_port_out(uo), .user_port_oe(ue), .system_control_port_in(si),
		.system_control_port_out(so), .system_control_port_oe(se),
		.peripheral_control_port_in(pi), .peripheral_control_port_out(po),
		.peripheral_control_port_oe(pe), .irq(irq), .external_watchdog_enable(wde),
		.external_watchdog_kick(wdk), .external_watchdog_fired(wdf),
		.undervoltage_indication(uv), .first_serial_port_mode(m1),
		.second_serial_port_mode(m2), .user_lamp_one(l1), .user_lamp_two(l2),
		.dip_switch_unit(dip));
	bgp_board bgp_board_i (.user_port_out(uo), .user_port_oe(ue), .system_control_port_out(so),
		.system_control_port_oe(se), .peripheral_control_port_out(po),
		.peripheral_control_port_oe(pe), .ext_user(ext[0]), .ext_sys(ext[1]),
		.ext_per(ext[2]), .user_port_in(ui), .system_control_port_in(si),
		.peripheral_control_port_in(pi), .kicks(kicks));
	task chk(input string nm, input [31:0] got, input [31:0] exp);
		samples_checked = samples_checked + 1;
		if (got !== exp) begin
			fails = fails + 1;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task wait_ready;
		integer n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1) begin
			n = n + 1;
			if (n > 20) begin
				fails = fails + 1;
				tally_and_finish;
			end
			@(posedge hclk);
		end
	endtask
	// one single word transfer; entered just after a rising edge
	task xfer(input w, input [9:0] idx, input [31:0] wd);
		hsel <= 1;
		htrans <= 2'h2;
		haddr <= {20'h0, idx, 2'h0};
		hwrite <= w;
		hsize <= `BGP_HSIZE_WORD;
		wait_ready;
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready;
		rd = hrdata;
	endtask
	task sc_reset;
		reg [9:0] i;
		for (i = 0; i < 3; i = i + 1) begin
			xfer(0, `BGP_IDX_P0_VALUES + i, 0);
			chk("values", rd, ext[i]);
			xfer(0, `BGP_IDX_P0_DIRS + i, 0);
			chk("dirs", rd, 0);
		end
		xfer(0, 10'h3ff, 0);
		chk("unmapped", rd, 0);
	endtask
	task sc_user;
		xfer(1, `BGP_IDX_P0_DIRS, 32'h0f);
		xfer(1, `BGP_IDX_P0_VALUES, 32'ha5);
		xfer(0, `BGP_IDX_P0_VALUES, 0);
		chk("p0 oe", ue, 8'h0f);
		chk("p0 out", uo & ue, 8'h05);
		chk("p0 read", rd, 8'h35);
	endtask
	task sc_system;
		xfer(1, `BGP_IDX_P1_DIRS, 32'hff);
		xfer(0, `BGP_IDX_P1_DIRS, 0);
		chk("p1 dirs", rd, 8'ha6);
		xfer(1, `BGP_IDX_P1_VALUES, 32'ha6);
		repeat (2) @(posedge hclk);
		chk("p1 drive", so & se, 8'h06);
		chk("wd on", wde, 1);
		fw <= 1;
		xfer(1, `BGP_IDX_P1_VALUES, 32'ha4);
		repeat (2) @(posedge hclk);
		chk("p1 fw drive", so & se, 8'ha4);
		chk("kicks", kicks, 2);
		chk("kick pulses", pulses, 2);
		fw <= 0;
	endtask
	task sc_serial;
		reg [9:0] i;
		reg [1:0] em;
		xfer(1, `BGP_IDX_P2_DIRS, 32'h3f);
		for (i = 0; i < 4; i = i + 1) begin
			xfer(1, `BGP_IDX_P2_VALUES, {26'h0, i[1:0], i[1:0], i[1:0]});
			repeat (2) @(posedge hclk);
			em = i == 1 ? `BGP_MODE_RS422 : (i == 3 ? `BGP_MODE_RS485 : `BGP_MODE_RS232);
			chk("mode one", m1, em);
			chk("mode two", m2, em);
			chk("lamps", {l2, l1}, i[1:0]);
		end
	endtask
	task sc_inputs;
		xfer(0, `BGP_IDX_EVT_STATUS, 0);
		xfer(1, `BGP_IDX_EVT_MASK, 32'h200);
		ext[1] <= 8'hfe;
		ext[2] <= 8'h7f;
		repeat (5) @(posedge hclk);
		chk("irq", irq, 1);
		chk("undervoltage", uv, 1);
		chk("fired", wdf, 1);
		chk("switches", dip, 2'h2);
		xfer(0, `BGP_IDX_EVT_STATUS, 0);
		chk("events", rd, 32'h700);
		repeat (2) @(posedge hclk);
		chk("irq clear", irq, 0);
		xfer(0, `BGP_IDX_P1_VALUES, 0);
		chk("p1 read", rd, 8'hfc);
	endtask
	initial begin
		repeat (2) @(posedge hclk);
		hresetn <= 1;
		sc_reset;
		sc_user;
		sc_system;
		sc_serial;
		sc_inputs;
		tally_and_finish;
	end
endmodule
